/* File: hw/dpll_lock.sv */
`timescale 1ns/1ps
`default_nettype none
module dpll_lock
	import dpll_pkg::*;
#(
	parameter int SECTOR_WORDS = SECTOR_WORDS_DEF
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         hw_reset,
	input  wire logic         cmd_valid,
	input  wire dpll_cmd_s    cmd,
	output logic              cmd_ready,
	input  wire logic         dat_valid,
	input  wire logic [15:0]  dat_word,
	output var  logic         rsp_done,
	output var  logic         rsp_abort,
	output var  logic         erase_start,
	output var  logic [15:0]  id_word92,
	output var  logic [15:0]  id_word128,
	input  wire logic [7:0]   bus_addr,
	input  wire logic [31:0]  bus_wdata,
	input  wire logic         bus_wr,
	input  wire logic         bus_rd,
	output var  logic [31:0]  bus_rdata
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RECV,
		ST_EXEC
	} dpll_state_e;

	function automatic logic pw_match(input dpll_pw_t a, input dpll_pw_t b);
		// Every bit takes part, so a partial match never passes.
		return a == b;
	endfunction : pw_match

	function automatic logic is_security(input logic [7:0] op);
		return op == OP_SET_PW || op == OP_UNLOCK || op == OP_ERASE_PREP ||
			op == OP_ERASE_UNIT || op == OP_FREEZE || op == OP_DISABLE_PW;
	endfunction : is_security

	function automatic logic needs_sector(input logic [7:0] op);
		return op == OP_SET_PW || op == OP_UNLOCK || op == OP_ERASE_UNIT ||
			op == OP_DISABLE_PW;
	endfunction : needs_sector

	dpll_state_e  state_reg;
	dpll_cmd_s    cmd_reg;
	dpll_pw_t     user_pw_reg;
	dpll_pw_t     master_pw_reg;
	logic [15:0]  master_rev_reg;
	logic         enabled_reg;
	logic         level_reg;
	logic         locked_reg;
	logic         frozen_reg;
	logic         pend_reg;
	logic [2:0]   tries_reg;
	logic [31:0]  ctrl_reg;
	dpll_sector_s sector;
	logic         sector_done;
	logic         rx_start;

	logic         abort_c;
	logic         do_set_user;
	logic         do_set_master;
	logic         do_unlock;
	logic         do_dec;
	logic         do_erase;
	logic         do_disable;
	logic         do_freeze;
	logic         do_prep;
	logic         exec;
	logic         supported;
	logic         expired;
	logic         user_ok;
	logic         master_ok;
	logic         pick_ok;
	logic         id_master;
	dpll_status_s status;
	dpll_id128_s  id128;

	assign cmd_ready = state_reg == ST_IDLE;
	assign rx_start  = cmd_valid && cmd_ready && needs_sector(cmd.opcode);
	assign exec      = state_reg == ST_EXEC && !hw_reset;
	assign supported = ctrl_reg[CTRL_SUPPORT_BIT];
	assign expired   = tries_reg == TRIES_SPENT;
	assign id_master = sector.ctrl[CW_IDENT_BIT];
	assign user_ok   = pw_match(sector.pw, user_pw_reg);
	assign master_ok = pw_match(sector.pw, master_pw_reg);
	assign pick_ok   = id_master ? master_ok : user_ok;

	dpll_sector_rx #(
		.SECTOR_WORDS(SECTOR_WORDS)
	) u_rx (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.start     (rx_start),
		.cancel    (hw_reset),
		.dat_valid (dat_valid),
		.dat_word  (dat_word),
		.sector    (sector),
		.done      (sector_done)
	);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else if (hw_reset) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_valid) begin
						state_reg <= needs_sector(cmd.opcode) ? ST_RECV : ST_EXEC;
					end
				end
				ST_RECV: begin
					if (sector_done) begin
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_reg <= '0;
		end else if (cmd_valid && cmd_ready) begin
			cmd_reg <= cmd;
		end
	end

	always_comb begin
		abort_c       = 1'b0;
		do_set_user   = 1'b0;
		do_set_master = 1'b0;
		do_unlock     = 1'b0;
		do_dec        = 1'b0;
		do_erase      = 1'b0;
		do_disable    = 1'b0;
		do_freeze     = 1'b0;
		do_prep       = 1'b0;
		if (!supported && is_security(cmd_reg.opcode)) begin
			abort_c = 1'b1;
		end else begin
			unique case (cmd_reg.opcode)
				OP_SET_PW: begin
					if (locked_reg || frozen_reg) begin
						abort_c = 1'b1;
					end else if (id_master) begin
						if (sector.rev > REV_MAX) begin
							abort_c = 1'b1;
						end else begin
							do_set_master = 1'b1;
						end
					end else begin
						do_set_user = 1'b1;
					end
				end
				OP_UNLOCK: begin
					if (frozen_reg || expired) begin
						abort_c = 1'b1;
					end else if (id_master && level_reg == LEVEL_MAX) begin
						abort_c = 1'b1;
					end else if (pick_ok) begin
						do_unlock = 1'b1;
					end else begin
						abort_c = 1'b1;
						do_dec  = locked_reg;
					end
				end
				OP_ERASE_PREP: begin
					if (frozen_reg) begin
						abort_c = 1'b1;
					end else begin
						do_prep = 1'b1;
					end
				end
				OP_ERASE_UNIT: begin
					if (frozen_reg || expired || !pend_reg) begin
						abort_c = 1'b1;
					end else if (pick_ok) begin
						do_erase = 1'b1;
					end else begin
						abort_c = 1'b1;
					end
				end
				OP_FREEZE: begin
					if (locked_reg) begin
						abort_c = 1'b1;
					end else begin
						do_freeze = 1'b1;
					end
				end
				OP_DISABLE_PW: begin
					if (locked_reg || frozen_reg || !pick_ok) begin
						abort_c = 1'b1;
					end else begin
						do_disable = 1'b1;
					end
				end
				default: begin
					abort_c = cmd_reg.media && locked_reg;
				end
			endcase
		end
	end

	// Passwords live only in flip-flops, so power-on brings back factory values.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			user_pw_reg    <= '0;
			master_pw_reg  <= FACTORY_MASTER_PW;
			master_rev_reg <= FACTORY_REV;
		end else if (exec && do_set_user) begin
			user_pw_reg <= sector.pw;
		end else if (exec && do_set_master) begin
			master_pw_reg  <= sector.pw;
			master_rev_reg <= sector.rev;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			enabled_reg <= 1'b0;
			level_reg   <= LEVEL_HIGH;
		end else if (exec && do_set_user) begin
			enabled_reg <= 1'b1;
			level_reg   <= sector.ctrl[CW_LEVEL_BIT];
		end else if (exec && (do_erase || do_disable)) begin
			enabled_reg <= 1'b0;
		end
	end

	// A new user password arms the lock but never locks until the next hw_reset.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			locked_reg <= 1'b0;
		end else if (hw_reset) begin
			locked_reg <= enabled_reg;
		end else if (exec && (do_unlock || do_erase)) begin
			locked_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			frozen_reg <= 1'b0;
		end else if (hw_reset) begin
			frozen_reg <= 1'b0;
		end else if (exec && do_freeze) begin
			frozen_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tries_reg <= UNLOCK_TRIES;
		end else if (hw_reset) begin
			tries_reg <= UNLOCK_TRIES;
		end else if (exec && do_dec && !expired) begin
			tries_reg <= tries_reg - 3'h1;
		end
	end

	// Commands run one at a time, so the next executed command decides the flag.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend_reg <= 1'b0;
		end else if (hw_reset) begin
			pend_reg <= 1'b0;
		end else if (exec) begin
			pend_reg <= do_prep;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rsp_done    <= 1'b0;
			rsp_abort   <= 1'b0;
			erase_start <= 1'b0;
		end else begin
			rsp_done    <= exec;
			erase_start <= exec && do_erase;
			if (exec) begin
				rsp_abort <= abort_c;
			end
		end
	end

	always_comb begin
		status         = '0;
		status.tries   = tries_reg;
		status.pend    = pend_reg;
		status.level   = level_reg;
		status.frozen  = frozen_reg;
		status.locked  = locked_reg;
		status.enabled = enabled_reg;
		id128           = '0;
		id128.level     = level_reg;
		id128.expired   = expired;
		id128.frozen    = frozen_reg;
		id128.locked    = locked_reg;
		id128.enabled   = enabled_reg;
		id128.supported = supported;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			id_word92  <= FACTORY_REV;
			id_word128 <= '0;
		end else begin
			id_word92  <= master_rev_reg;
			id_word128 <= id128;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (bus_wr && bus_addr == REG_CTRL) begin
			ctrl_reg <= 32'(bus_wdata[CTRL_SUPPORT_BIT]);
		end
	end

	// Read data stand for exactly one cycle and are zero otherwise.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata <= '0;
		end else if (bus_rd) begin
			unique case (bus_addr)
				REG_STATUS: bus_rdata <= 32'(status);
				REG_MREV:   bus_rdata <= 32'(master_rev_reg);
				REG_CTRL:   bus_rdata <= ctrl_reg;
				REG_ID128:  bus_rdata <= 32'(id128);
				default:    bus_rdata <= '0;
			endcase
		end else begin
			bus_rdata <= '0;
		end
	end

endmodule : dpll_lock
`default_nettype wire

/* File: hw/dpll_pkg.sv */
`default_nettype none
package dpll_pkg;

	localparam int SECTOR_WORDS_DEF = 256;
	localparam int PW_BITS          = 256;

	typedef logic [PW_BITS-1:0] dpll_pw_t;

	localparam logic [7:0] OP_SET_PW     = 8'hF1;
	localparam logic [7:0] OP_UNLOCK     = 8'hF2;
	localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
	localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
	localparam logic [7:0] OP_FREEZE     = 8'hF5;
	localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

	localparam dpll_pw_t    FACTORY_MASTER_PW = {16{16'h2020}};
	localparam logic [15:0] FACTORY_REV       = 16'hFFFE;
	localparam logic [15:0] REV_MAX           = 16'hFFFD;
	localparam logic [2:0]  UNLOCK_TRIES      = 3'h5;
	localparam logic [2:0]  TRIES_SPENT       = 3'h0;

	localparam int CW_IDENT_BIT = 0;
	localparam int CW_LEVEL_BIT = 8;
	localparam int WI_CTRL      = 0;
	localparam int WI_PW_FIRST  = 1;
	localparam int WI_PW_LAST   = 16;
	localparam int WI_REV       = 17;

	localparam logic LEVEL_HIGH = 1'b0;
	localparam logic LEVEL_MAX  = 1'b1;

	localparam logic [7:0]  REG_STATUS       = 8'h00;
	localparam logic [7:0]  REG_MREV         = 8'h04;
	localparam logic [7:0]  REG_CTRL         = 8'h08;
	localparam logic [7:0]  REG_ID128        = 8'h0C;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
	localparam int          CTRL_SUPPORT_BIT = 0;

	typedef struct packed {
		logic [7:0] opcode;
		logic       media;
	} dpll_cmd_s;

	typedef struct packed {
		logic [15:0] ctrl;
		dpll_pw_t    pw;
		logic [15:0] rev;
	} dpll_sector_s;

	typedef struct packed {
		logic [2:0] tries;
		logic       pend;
		logic       level;
		logic       frozen;
		logic       locked;
		logic       enabled;
	} dpll_status_s;

	typedef struct packed {
		logic [9:0] rsvd;
		logic       level;
		logic       expired;
		logic       frozen;
		logic       locked;
		logic       enabled;
		logic       supported;
	} dpll_id128_s;

endpackage : dpll_pkg
`default_nettype wire

/* File: hw/dpll_sector_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module dpll_sector_rx
	import dpll_pkg::*;
#(
	parameter int SECTOR_WORDS = SECTOR_WORDS_DEF
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic         cancel,
	input  wire logic         dat_valid,
	input  wire logic [15:0]  dat_word,
	output var  dpll_sector_s sector,
	output var  logic         done
);

	// The word index is nine bits wide and must reach the revision word.
	if (SECTOR_WORDS < WI_REV + 1 || SECTOR_WORDS > 511) begin : g_bad_words
		$error("SECTOR_WORDS out of range");
	end

	logic [8:0] idx_reg;
	logic       busy_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
			idx_reg  <= '0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (cancel) begin
				busy_reg <= 1'b0;
			end else if (start) begin
				busy_reg <= 1'b1;
				idx_reg  <= '0;
			end else if (busy_reg && dat_valid) begin
				idx_reg <= idx_reg + 9'd1;
				if (idx_reg == 9'(SECTOR_WORDS - 1)) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
				end
			end
		end
	end

	// Reserved words are counted but never stored.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sector <= '0;
		end else if (busy_reg && dat_valid && !start && !cancel) begin
			if (idx_reg == 9'(WI_CTRL)) begin
				sector.ctrl <= dat_word;
			end
			if (idx_reg >= 9'(WI_PW_FIRST) && idx_reg <= 9'(WI_PW_LAST)) begin
				sector.pw <= {dat_word, sector.pw[PW_BITS-1:16]};
			end
			if (idx_reg == 9'(WI_REV)) begin
				sector.rev <= dat_word;
			end
		end
	end

endmodule : dpll_sector_rx
`default_nettype wire

/* File: tb/dpll_lock_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dpll_lock_sva
	import dpll_pkg::*;
#(
	parameter int SECTOR_WORDS = SECTOR_WORDS_DEF
) (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        hw_reset,
	input wire logic        cmd_valid,
	input wire dpll_cmd_s   cmd,
	input wire logic        cmd_ready,
	input wire logic        dat_valid,
	input wire logic [15:0] dat_word,
	input wire logic        rsp_done,
	input wire logic        rsp_abort,
	input wire logic        erase_start,
	input wire logic [15:0] id_word92,
	input wire logic [15:0] id_word128,
	input wire logic [7:0]  bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire logic take = cmd_valid && cmd_ready;
	wire logic sec = cmd.opcode inside {OP_SET_PW, OP_UNLOCK, OP_ERASE_UNIT, OP_DISABLE_PW};
	property p_media; take && cmd.media && id_word128[2] |-> ##2 rsp_done && rsp_abort; endproperty
	a_media: assert property (p_media) else $error("media command not refused");
	property p_short; take && !sec |-> ##2 rsp_done; endproperty
	a_short: assert property (p_short) else $error("short command late");
	property p_long; take && sec |=> !rsp_done [*8]; endproperty
	a_long: assert property (p_long) else $error("sector command ended early");
	property p_erase; erase_start |-> rsp_done && !rsp_abort && !id_word128[4] && !id_word128[3]; endproperty
	a_erase: assert property (p_erase) else $error("erase started wrongly");
	property p_prep; take && cmd.opcode == OP_ERASE_PREP && id_word128[3] |-> ##2 rsp_abort; endproperty
	a_prep: assert property (p_prep) else $error("prepare not refused while frozen");
	property p_busy; take |=> !cmd_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_pulse; rsp_done |=> !rsp_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	property p_hold; $changed(rsp_abort) |-> rsp_done; endproperty
	a_hold: assert property (p_hold) else $error("abort moved without done");
	property p_rdata; !$past(bus_rd) |-> bus_rdata == 32'h0000_0000; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule : dpll_lock_sva
`default_nettype wire

/* File: tb/dpll_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpll_host_model
	import dpll_pkg::*;
#(
	parameter int SW = 18
) (
	input  wire logic        core_clk,
	input  wire logic        cmd_ready,
	input  wire logic        rsp_done,
	input  wire logic        rsp_abort,
	input  wire logic        erase_start,
	output var  logic        cmd_valid,
	output var  dpll_cmd_s   cmd,
	output var  logic        dat_valid,
	output var  logic [15:0] dat_word
);
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		dat_valid = 1'b0;
		dat_word = 16'h0000;
	end
	// The answer is watched while words go out too, since an early abort must not hang us.
	task automatic issue(input logic [7:0] op, input logic med, input logic [15:0] ctl,
		input dpll_pw_t pw, input logic [15:0] rev, input int stall,
		output logic ab, output logic er, output logic ok);
		int          i;
		int          s;
		logic        got;
		logic [15:0] w;
		i = 0;
		s = stall;
		got = 1'b0;
		ok = 1'b0;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{opcode: op, media: med};
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge core_clk);
			ok = cmd_ready;
		end
		cmd_valid <= 1'b0;
		for (int n = 0; n < SW + 60 && ok && !got; n++) begin
			if (op inside {OP_SET_PW, OP_UNLOCK, OP_ERASE_UNIT, OP_DISABLE_PW} && i < SW && !(i == 9 && s > 0)) begin
				w = (i == 0) ? ctl : (i <= 16) ? pw[16*(i-1) +: 16] : (i == 17) ? rev : ~w;
				dat_valid <= 1'b1;
				dat_word <= w;
				i++;
			end else begin
				s--;
				dat_valid <= 1'b0;
				dat_word <= ~dat_word;
			end
			@(posedge core_clk);
			got = rsp_done;
			ab = rsp_abort;
			er = erase_start;
		end
		dat_valid <= 1'b0;
		ok = ok && got;
	endtask : issue
endmodule : dpll_host_model
`default_nettype wire

/* File: tb/drive_password_lock_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_password_lock_logic_test;
	import dpll_pkg::*;
	localparam int          SW = 18;
	localparam dpll_pw_t    PU = {8{32'h0123_4567}};
	localparam dpll_pw_t    PM = {8{32'h89AB_CDEF}};
	localparam dpll_pw_t    BAD = PU ^ {8'h01, 248'h0};
	localparam logic [15:0] CU = 16'h0000;
	localparam logic [15:0] CM = 16'h0001;
	logic        core_clk, rstn, hw_reset, cmd_valid, cmd_ready, dat_valid;
	logic        rsp_done, rsp_abort, erase_start, bus_wr, bus_rd;
	logic [15:0] dat_word, id_word92, id_word128;
	logic [31:0] bus_wdata, bus_rdata, d;
	logic [7:0]  bus_addr;
	dpll_cmd_s   cmd;
	int          errors, n_compared, stall;
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	dpll_lock #(.SECTOR_WORDS(SW)) u_dpll_lock (.*);
	dpll_host_model #(.SW(SW)) u_dpll_host_model (.*);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		@(negedge core_clk);
		d = bus_rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic st(input logic [7:0] exp);
		rd(REG_STATUS);
		chk("status", d[7:0], exp);
	endtask : st
	task automatic run(input logic [7:0] op, input logic ab_x, input logic [15:0] c = CU,
		input dpll_pw_t pw = PU, input logic [15:0] rv = 16'h0000,
		input logic m = 1'b0, input logic er_x = 1'b0);
		logic ab, er, ok;
		u_dpll_host_model.issue(op, m, c, pw, rv, stall, ab, er, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH command %h expected done seen none", op);
			conclude();
		end else begin
			chk("abort", ab, ab_x);
			chk("erase", er, er_x);
		end
	endtask : run
	task automatic rst();
		rstn <= 1'b0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
	endtask : rst
	task automatic hwr();
		@(posedge core_clk);
		hw_reset <= 1'b1;
		@(posedge core_clk);
		hw_reset <= 1'b0;
		@(posedge core_clk);
	endtask : hwr
	task automatic t_factory();
		st(8'hA0);
		chk("id92", id_word92, 16'hFFFE);
		chk("id128", id_word128[0], 1'b1);
		rd(REG_MREV);
		chk("mrev", d, 32'h0000_FFFE);
		wr(REG_CTRL, 32'h0000_0000);
		run(OP_FREEZE, 1'b1);
		wr(REG_CTRL, CTRL_RESET);
		rd(8'h10);
		chk("unmapped", d, 32'h0000_0000);
		run(OP_UNLOCK, 1'b0, CM, FACTORY_MASTER_PW);
	endtask : t_factory
	task automatic t_master();
		stall = 3;
		run(OP_SET_PW, 1'b0, CM, PM, 16'h1234);
		stall = 0;
		st(8'hA0);
		chk("id92", id_word92, 16'h1234);
		run(OP_SET_PW, 1'b1, CM, PU, FACTORY_REV);
	endtask : t_master
	task automatic t_high();
		run(OP_SET_PW, 1'b0);
		st(8'hA1);
		run(8'h20, 1'b0, CU, PU, 16'h0000, 1'b1);
		hwr();
		st(8'hA3);
		run(8'h20, 1'b1, CU, PU, 16'h0000, 1'b1);
		run(8'hEC, 1'b0);
		run(OP_SET_PW, 1'b1);
		run(OP_UNLOCK, 1'b1, CU, BAD);
		st(8'h83);
		run(OP_UNLOCK, 1'b0, CM, PM);
		run(8'h20, 1'b0, CU, PU, 16'h0000, 1'b1);
		run(OP_UNLOCK, 1'b1, CU, BAD);
		st(8'h81);
	endtask : t_high
	task automatic t_spent();
		hwr();
		repeat (5) run(OP_UNLOCK, 1'b1, CU, BAD);
		st(8'h03);
		run(OP_UNLOCK, 1'b1);
		run(OP_ERASE_PREP, 1'b0);
		run(OP_ERASE_UNIT, 1'b1);
	endtask : t_spent
	task automatic t_max();
		run(OP_SET_PW, 1'b0, 16'h0100);
		hwr();
		run(OP_UNLOCK, 1'b1, CM, FACTORY_MASTER_PW);
		st(8'hAB);
		run(OP_ERASE_UNIT, 1'b1, CM, FACTORY_MASTER_PW);
		run(OP_ERASE_PREP, 1'b0);
		run(8'hEC, 1'b0);
		run(OP_ERASE_UNIT, 1'b1, CM, FACTORY_MASTER_PW);
		run(OP_ERASE_PREP, 1'b0);
		run(OP_ERASE_UNIT, 1'b1, CM, BAD);
		run(OP_ERASE_PREP, 1'b0);
		run(OP_ERASE_UNIT, 1'b0, CM, FACTORY_MASTER_PW, 16'h0000, 1'b0, 1'b1);
		st(8'hA8);
	endtask : t_max
	task automatic t_freeze();
		run(OP_FREEZE, 1'b0);
		st(8'hAC);
		run(OP_FREEZE, 1'b0);
		run(OP_SET_PW, 1'b1, CM, PM);
		run(OP_UNLOCK, 1'b1);
		run(OP_ERASE_PREP, 1'b1);
		hwr();
		st(8'hA8);
	endtask : t_freeze
	initial begin
		rstn = 1'b0;
		hw_reset = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0000_0000;
		errors = 0;
		n_compared = 0;
		stall = 0;
		rst();
		t_factory();
		t_master();
		t_high();
		t_spent();
		rst();
		t_max();
		t_freeze();
		conclude();
	end
endmodule : drive_password_lock_logic_test
bind dpll_lock dpll_lock_sva #(.SECTOR_WORDS(SECTOR_WORDS)) u_dpll_lock_sva (.*);
`default_nettype wire
